/* bench/pwm_current_limit_hiccup_test.sv */
// testbench: normal, limited, matched and hiccup operation of the controller
// assumes sense_model as far side; knobs change only at the start of a half
module pwm_current_limit_hiccup_test;
  timeunit 1ns;
  timeprecision 100ps;
  // short half period; timer scale gives a 240-cycle delay and a long hiccup
  localparam int HC = 60;
  localparam int DC = 4;
  localparam int CAP = 300;
  logic ref_clk = 0;
  logic resetn = 0;
  logic peak_mode_in = 0;
  logic trip_pin = 0;
  logic low_pin = 0;
  logic overload = 0;
  logic [7:0] duty = 8'h02;
  logic [7:0] lim_cyc = 8'h00;
  logic pwm_cmp_in, current_limit_sense, primary_out_a, primary_out_b, rect_out_a, rect_out_b;
  logic ramp_discharge, sense_clamp, ramp_sel_current, soft_start_pull_low;
  logic timer_charge, timer_decay, timer_discharge;
  int err_total = 0;
  int check_count = 0;
  int wq[$];
  int w = 0, cl = 0, hl = 0, cc = 0, t = 0, last_rise = -1, last_e = 0;
  logic last_side = 0;
  logic dis_seen = 0;
  logic [31:0] lfsr_r = 32'hB93B;

  always #5 ref_clk = ~ref_clk;

  pwm_current_limit_hiccup #(.HALF_CYC(HC), .DEAD_CYC(DC), .CAP_FC_PER_MV(CAP)) pwm_current_limit_hiccup_inst (
    .ref_clk(ref_clk), .resetn(resetn), .pwm_cmp_in(pwm_cmp_in), .current_limit_sense(current_limit_sense),
    .timer_trip_in(trip_pin), .timer_low_in(low_pin), .peak_mode_in(peak_mode_in),
    .primary_out_a(primary_out_a), .primary_out_b(primary_out_b), .rect_out_a(rect_out_a),
    .rect_out_b(rect_out_b), .ramp_discharge(ramp_discharge), .sense_clamp(sense_clamp),
    .ramp_sel_current(ramp_sel_current), .soft_start_pull_low(soft_start_pull_low),
    .timer_charge(timer_charge), .timer_decay(timer_decay), .timer_discharge(timer_discharge));

  sense_model sense_model_inst (
    .ref_clk(ref_clk), .primary_out_a(primary_out_a), .primary_out_b(primary_out_b),
    .sense_clamp(sense_clamp), .overload(overload), .duty_cyc(duty), .lim_cyc(lim_cyc),
    .pwm_cmp_in(pwm_cmp_in), .current_limit_sense(current_limit_sense));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_b(input logic exp, input logic got, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s: got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_w(input int lo, input int hi, input int got, input string what);
    check_count++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("BAD %0t %s: got %0d expected %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  function automatic logic [31:0] lfsr_step(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  // width model: comparator trip plus sync and register delay, floored at the minimum pulse
  function automatic int exp_w(input int d, input logic ov, input int lim);
    int e;
    e = d + 3;
    if (ov && lim + 3 < e) e = lim + 3;
    return (e < 10) ? 10 : e;
  endfunction

  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // sets the knobs at the start of a half and checks that half's pulse
  task automatic run(input int d, input logic ov, input int lim, input logic matched);
    int k;
    int e;
    for (k = 0; ramp_discharge && k < 400; k++) @(negedge ref_clk);
    for (k = 0; !ramp_discharge && k < 400; k++) @(negedge ref_clk);
    duty = d[7:0];
    overload = ov;
    lim_cyc = lim[7:0];
    e = matched ? last_e : exp_w(d, ov, lim);
    last_e = e;
    wq.delete();
    for (k = 0; wq.size() == 0 && k < 2 * HC; k++) @(negedge ref_clk);
    chk_w((e - 1 < 10) ? 10 : e - 1, e + 1, (wq.size() > 0) ? wq[0] : -1, "pulse width");
    $display("half done, width %0d", (wq.size() > 0) ? wq[0] : -1);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor on the falling edge, where registered outputs are settled
  always @(negedge ref_clk) begin
    t++;
    if (resetn) begin
      if (primary_out_a || primary_out_b) begin
        if (w == 0) begin
          chk_b(1'b1, sense_clamp, "clamp at rise");
          if (last_rise >= 0) chk_w(HC, HC, t - last_rise, "half spacing");
          if (last_rise >= 0) chk_b(~last_side, primary_out_b, "side order");
          last_rise = t;
          last_side = primary_out_b;
        end
        w++;
      end else if (w > 0) begin
        wq.push_back(w);
        w = 0;
      end
      chk_b(1'b0, (primary_out_a & rect_out_a) | (primary_out_b & rect_out_b), "rect overlap");
      if (timer_charge) cc++;
      if (timer_discharge) dis_seen = 1'b1;
      if (soft_start_pull_low) begin
        chk_b(1'b0, primary_out_a | primary_out_b | rect_out_a | rect_out_b, "gates in hiccup");
        hl++;
        cl = 0;
        last_rise = -1;
      end else begin
        chk_b(sense_clamp, ramp_discharge, "blanking pair");
        if (sense_clamp) cl++;
        else if (cl > 0) begin
          chk_w(DC + 7, DC + 7, cl, "clamp length");
          cl = 0;
        end
      end
    end
  end

  initial begin
    #600000;
    err_total++;
    $display("BAD %0t watchdog expired", $time);
    conclude();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i;
    int d;
    int k;
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk_b(1'b0, primary_out_a | primary_out_b | rect_out_a | rect_out_b | sense_clamp | timer_charge, "reset");
    resetn = 1;
    for (i = 0; i < 4; i++) begin
      lfsr_r = lfsr_step(lfsr_r);
      d = 8 + int'(lfsr_r[4:0]);
      run(d, 1'b0, 0, 1'b0);
    end
    run(1, 1'b0, 0, 1'b0);
    $display("normal halves done");
    // persistent overload: limited halves until the delay timer trips
    cc = 0;
    run(30, 1'b1, 12, 1'b0);
    for (k = 0; !soft_start_pull_low && k < 2000; k++) @(negedge ref_clk);
    chk_w(239, 241, cc, "delay before trip");
    overload = 1'b0;
    for (k = 0; soft_start_pull_low && k < 30000; k++) @(negedge ref_clk);
    // 2100 mV of charge decayed in steps of 27 per cycle
    chk_w(23332, 23338, hl, "hiccup length");
    run(12, 1'b0, 0, 1'b0);
    chk_b(1'b1, dis_seen, "timer reset");
    $display("hiccup test done");
    for (i = 0; i < 2; i++) begin
      peak_mode_in = i[0];
      // the slow decay must empty the timer before the next limit event
      repeat (5000) @(negedge ref_clk);
      chk_b(i[0], ramp_sel_current, "mode select");
      cc = 0;
      run(30, 1'b1, 12, 1'b0);
      run(2, 1'b0, 0, 1'b1);
      run(2, 1'b0, 0, 1'b0);
      chk_b(1'b1, cc > 0, "timer charged");
      repeat (HC) @(negedge ref_clk);
      chk_b(1'b1, timer_decay, "timer decays");
      chk_b(1'b0, soft_start_pull_low, "no trip");
      $display("limit test done, mode %0d", i);
    end
    // pin comparisons: the trip pin forces hiccup, an armed low pin ends it at once
    for (k = 0; ramp_discharge && k < 100; k++) @(negedge ref_clk);
    trip_pin = 1'b1;
    for (k = 0; !soft_start_pull_low && k < 10; k++) @(negedge ref_clk);
    trip_pin = 1'b0;
    chk_b(1'b1, soft_start_pull_low, "trip pin");
    repeat (20) @(negedge ref_clk);
    low_pin = 1'b1;
    for (k = 0; soft_start_pull_low && k < 10; k++) @(negedge ref_clk);
    low_pin = 1'b0;
    chk_b(1'b0, soft_start_pull_low, "low pin");
    $display("pin test done");
    conclude();
  end
endmodule

/* bench/sense_model.sv */
// partner: sense network, ramp comparator and gate load seen by the controller
// assumes primary outputs registered on ref_clk; knobs change at falling edges
module sense_model (
  // clock
  input wire logic ref_clk,
  // controller outputs
  input wire logic primary_out_a,
  input wire logic primary_out_b,
  input wire logic sense_clamp,
  // scenario knobs
  input wire logic overload,
  input wire logic [7:0] duty_cyc,
  input wire logic [7:0] lim_cyc,
  // comparisons
  output logic pwm_cmp_in,
  output logic current_limit_sense
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] on_cnt_r = 8'h00;

  // current grows with on-time, so on-time stands in for sensed current plus slope
  always @(posedge ref_clk) begin
    if (primary_out_a || primary_out_b) on_cnt_r <= on_cnt_r + 8'h01;
    else on_cnt_r <= 8'h00;
  end

  assign pwm_cmp_in = on_cnt_r >= duty_cyc;
  // the clamp switch pulls the pin down, so nothing passes while it is on
  assign current_limit_sense = overload && on_cnt_r >= lim_cyc && !sense_clamp;
endmodule

/* inc/ocp_timer_if.sv */
// interface: control and status of the overcurrent delay / hiccup timer counter
// both ends sit on the same clock; no timing of its own
interface ocp_timer_if;
  import pwm_hiccup_pkg::*;
  logic charge;
  logic decay;
  logic load_top;
  logic clear;
  logic [TIMER_W-1:0] trip_lvl;
  logic [TIMER_W-1:0] top_lvl;
  logic [TIMER_W-1:0] low_lvl;
  logic [TIMER_W-1:0] level;
  logic at_trip;
  logic at_low;

  modport ctrl (output charge, decay, load_top, clear, trip_lvl, top_lvl, low_lvl,
                input level, at_trip, at_low);
  modport timer (input charge, decay, load_top, clear, trip_lvl, top_lvl, low_lvl,
                 output level, at_trip, at_low);
endinterface

/* inc/pwm_hiccup_pkg.sv */
// package: constants, timing counts and state encodings of the pwm current-limit/hiccup controller
// assumes a single 100 MHz clock; analog comparisons arrive as asynchronous levels
// Overview of operation
// - ramp runs at twice the switching rate, one ramp period per primary output.
// - one ramp sets on-time of both primary and rectifier outputs.
// - blanking pulse of dead time plus 70 ns holds ramp input discharged.
// - current sense above 0.5 V ends the active primary pulse once past minimum width, except in a matched half.
// - current limit works the same in voltage and peak-current mode.
// - under persistent overcurrent the sense comparator sets every other pulse width; matched halves copy it.
// - current-sense input is clamped low from the start of every cycle.
// - clamp stays on 70 ns after a primary output rises.
// - after a limited pulse the other output gets the same on-time next half.
// - any current-limit event starts charging the timer at 75 uA.
// - overcurrent gone before 0.6 V trip lets the timer decay at 2.7 uA.
// - timer at 0.6 V forces all four outputs off and enters hiccup.
// - hiccup holds outputs low, grounds soft start, decays timer to 0.3 V.
// - at the lower level the timer is fully reset for the next event.
// - after hiccup the converter restarts through a full soft start.
// - limit time before shutdown is capacitance times 0.6 V over 75 uA.
// - hiccup off-time is capacitance times 2.1 V over 2.7 uA.
// - soft-start node held low from shutdown until the timer is reset.
// - no primary pulse is narrower than 100 ns, except one cut short by a trip.
package pwm_hiccup_pkg;

  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned CLK_FREQ_KHZ = 100000;

  // switching rate and the programmed dead time
  localparam int unsigned SW_FREQ_KHZ = 150;
  localparam int unsigned HALF_PERIOD_CYC = CLK_FREQ_KHZ / (2 * SW_FREQ_KHZ);
  localparam int unsigned DEAD_TIME_NS = 150;
  localparam int unsigned DEAD_TIME_CYC = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // blanking extension and minimum pulse, least times rounded up
  localparam int unsigned BLANK_EXTRA_NS = 70;
  localparam int unsigned BLANK_EXTRA_CYC = (BLANK_EXTRA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned MIN_PULSE_NS = 100;
  localparam int unsigned MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // timer currents and levels; the counter holds charge in femtocoulombs
  localparam int unsigned CHARGE_NA = 75000;
  localparam int unsigned DECAY_NA = 2700;
  localparam int unsigned CHARGE_FC_PER_CYC = CHARGE_NA * CLK_PERIOD_NS / 1000;
  localparam int unsigned DECAY_FC_PER_CYC = DECAY_NA * CLK_PERIOD_NS / 1000;
  localparam int unsigned TRIP_MV = 600;
  localparam int unsigned TOP_MV = 2400;
  localparam int unsigned LOW_MV = 300;
  localparam int unsigned TIMER_FC_PER_MV = 1000000;
  localparam int unsigned TIMER_W = 32;
  localparam int unsigned PHASE_W = 16;

  typedef enum logic [1:0] {
    ST_RUN = 2'h0,
    ST_HICCUP = 2'h1,
    ST_RESTART = 2'h2
  } mode_t;

endpackage

/* verilog/ocp_timer.sv */
// up/down counter standing in for the timer capacitor charge
// assumes the controller never asks for charge and decay in the same cycle
module ocp_timer
  import pwm_hiccup_pkg::*;
#(
  parameter int unsigned CHARGE_STEP = CHARGE_FC_PER_CYC,
  parameter int unsigned DECAY_STEP = DECAY_FC_PER_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // control side
  ocp_timer_if.timer tif
);

  localparam logic [TIMER_W-1:0] CHG = TIMER_W'(CHARGE_STEP);
  localparam logic [TIMER_W-1:0] DCY = TIMER_W'(DECAY_STEP);

  logic [TIMER_W-1:0] level_r;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (!resetn || tif.clear) begin
      level_r <= '0;
    end else if (tif.load_top) begin
      level_r <= tif.top_lvl;
    end else if (tif.charge) begin
      // saturate instead of wrapping to zero
      level_r <= (level_r > ~CHG) ? '1 : level_r + CHG;
    end else if (tif.decay) begin
      level_r <= (level_r < DCY) ? '0 : level_r - DCY;
    end
  end

  // compared straight off the counter; a registered compare would charge one cycle past the trip level
  assign tif.level = level_r;
  assign tif.at_trip = level_r >= tif.trip_lvl;
  assign tif.at_low = level_r <= tif.low_lvl;

endmodule

/* verilog/pwm_current_limit_hiccup.sv */
// top: pwm timing, cycle-by-cycle current limit, matched duty and hiccup control
// assumes analog comparator outputs as asynchronous levels and an external soft-start circuit
module pwm_current_limit_hiccup
  import pwm_hiccup_pkg::*;
#(
  parameter int unsigned HALF_CYC = HALF_PERIOD_CYC,
  parameter int unsigned DEAD_CYC = DEAD_TIME_CYC,
  parameter int unsigned CAP_FC_PER_MV = TIMER_FC_PER_MV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic resetn,
  // analog comparisons
  input wire logic pwm_cmp_in,
  input wire logic current_limit_sense,
  input wire logic timer_trip_in,
  input wire logic timer_low_in,
  input wire logic peak_mode_in,
  // power stage
  output logic primary_out_a,
  output logic primary_out_b,
  output logic rect_out_a,
  output logic rect_out_b,
  // analog switches
  output logic ramp_discharge,
  output logic sense_clamp,
  output logic ramp_sel_current,
  output logic soft_start_pull_low,
  output logic timer_charge,
  output logic timer_decay,
  output logic timer_discharge
);

  localparam logic [PHASE_W-1:0] HALF_LAST = PHASE_W'(HALF_CYC - 1);
  localparam logic [PHASE_W-1:0] DEAD_P = PHASE_W'(DEAD_CYC);
  localparam logic [PHASE_W-1:0] BLANK_END = PHASE_W'(DEAD_CYC + BLANK_EXTRA_CYC);
  localparam logic [PHASE_W-1:0] MIN_LAST = PHASE_W'(MIN_PULSE_CYC - 1);
  localparam logic [PHASE_W-1:0] ONE = 16'h0001;
  localparam logic [TIMER_W-1:0] TRIP_LVL = TIMER_W'(longint'(TRIP_MV) * longint'(CAP_FC_PER_MV));
  localparam logic [TIMER_W-1:0] TOP_LVL = TIMER_W'(longint'(TOP_MV) * longint'(CAP_FC_PER_MV));
  localparam logic [TIMER_W-1:0] LOW_LVL = TIMER_W'(longint'(LOW_MV) * longint'(CAP_FC_PER_MV));

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [4:0] async_in;
  logic [4:0] sync1_r;
  logic [4:0] sync2_r;
  logic pwm_s;
  logic limit_s;
  logic trip_s;
  logic low_s;
  logic peak_s;

  assign async_in = {peak_mode_in, timer_low_in, timer_trip_in, current_limit_sense, pwm_cmp_in};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!resetn) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= async_in[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  assign pwm_s = sync2_r[0];
  assign limit_s = sync2_r[1];
  assign trip_s = sync2_r[2];
  assign low_s = sync2_r[3];
  assign peak_s = sync2_r[4];

  ////////////////////////////////////////////////////////////////////////////
  // state
  mode_t mode_r;
  logic [PHASE_W-1:0] phase_r;
  logic side_r;
  logic pri_a_r;
  logic pri_b_r;
  logic [PHASE_W-1:0] on_cnt_r;
  logic [PHASE_W-1:0] match_w_r;
  logic [PHASE_W-1:0] since_off_r;
  logic limit_seen_r;
  logic matched_r;
  logic oc_active_r;
  logic low_armed_r;
  logic rect_a_r;
  logic rect_b_r;
  logic discharge_r;
  logic clamp_r;
  logic ramp_sel_r;
  logic ss_pull_r;
  logic charge_r;
  logic decay_r;
  logic tdis_r;

  logic trip;
  logic low;
  logic run_ok;
  logic half_end;
  logic pri_on;
  logic start_now;
  logic end_now;
  logic limit_end;
  logic charge_nxt;

  ocp_timer_if tif ();

  ocp_timer #(
    .CHARGE_STEP(CHARGE_FC_PER_CYC),
    .DECAY_STEP(DECAY_FC_PER_CYC)
  ) u_timer (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tif(tif)
  );

  // either the modelled counter or the real node can trip; the low
  // comparator is only believed once it has been seen low in hiccup
  assign trip = (mode_r == ST_RUN) && (tif.at_trip || trip_s);
  assign low = (mode_r == ST_HICCUP) && (tif.at_low || (low_s && low_armed_r));
  assign run_ok = (mode_r == ST_RUN) && !trip;
  assign half_end = phase_r == HALF_LAST;
  assign pri_on = pri_a_r || pri_b_r;
  assign start_now = run_ok && (phase_r == DEAD_P) && !pwm_s && !half_end;
  assign charge_nxt = run_ok && (oc_active_r || limit_end);

  assign tif.charge = charge_r;
  assign tif.decay = decay_r;
  assign tif.load_top = trip;
  assign tif.clear = low;
  assign tif.trip_lvl = TRIP_LVL;
  assign tif.top_lvl = TOP_LVL;
  assign tif.low_lvl = LOW_LVL;

  ////////////////////////////////////////////////////////////////////////////
  // pulse termination: limit in matched half ignored, min width first
  always_comb begin
    end_now = 1'b0;
    limit_end = 1'b0;
    if (pri_on) begin
      if (half_end) begin
        end_now = 1'b1;
      end else if (on_cnt_r >= MIN_LAST) begin
        if (matched_r) begin
          end_now = (on_cnt_r + ONE) >= match_w_r;
        end else if (limit_s && !clamp_r) begin
          end_now = 1'b1;
          limit_end = 1'b1;
        end else if (pwm_s) begin
          end_now = 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // operating mode
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      mode_r <= ST_RUN;
    end else begin
      case (mode_r)
        ST_RUN: if (trip) mode_r <= ST_HICCUP;
        ST_HICCUP: if (low) mode_r <= ST_RESTART;
        ST_RESTART: mode_r <= ST_RUN;
        default: mode_r <= ST_RUN;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || mode_r != ST_HICCUP) begin
      low_armed_r <= 1'b0;
    end else if (!low_s) begin
      low_armed_r <= 1'b1;
    end
  end

  // soft-start node held from shutdown until timer reset; its release
  // starts a fresh soft start rather than the old duty
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      ss_pull_r <= 1'b0;
    end else if (trip) begin
      ss_pull_r <= 1'b1;
    end else if (low) begin
      ss_pull_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // ramp timebase, one period per half switching cycle
  always_ff @(posedge ref_clk) begin
    if (!resetn || !run_ok) begin
      phase_r <= '0;
      side_r <= 1'b0;
    end else if (half_end) begin
      phase_r <= '0;
      side_r <= ~side_r;
    end else begin
      phase_r <= phase_r + ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || !run_ok) begin
      discharge_r <= 1'b0;
      clamp_r <= 1'b0;
    end else begin
      discharge_r <= phase_r < BLANK_END;
      clamp_r <= phase_r < BLANK_END;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // primary outputs
  always_ff @(posedge ref_clk) begin
    if (!resetn || !run_ok) begin
      pri_a_r <= 1'b0;
      pri_b_r <= 1'b0;
    end else begin
      pri_a_r <= (start_now && !side_r) || (pri_a_r && !end_now);
      pri_b_r <= (start_now && side_r) || (pri_b_r && !end_now);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || start_now) begin
      on_cnt_r <= '0;
    end else if (pri_on) begin
      on_cnt_r <= on_cnt_r + ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || pri_on) begin
      since_off_r <= '0;
    end else if (since_off_r < DEAD_P) begin
      since_off_r <= since_off_r + ONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // matched duty and overcurrent tracking
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      match_w_r <= '0;
    end else if (limit_end) begin
      match_w_r <= on_cnt_r + ONE;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || !run_ok) begin
      limit_seen_r <= 1'b0;
      matched_r <= 1'b0;
    end else if (half_end) begin
      limit_seen_r <= 1'b0;
      // a matched half never arms another match, so volt-seconds stay paired
      matched_r <= limit_seen_r && !matched_r;
    end else if (limit_end) begin
      limit_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn || !run_ok) begin
      oc_active_r <= 1'b0;
    end else if (limit_end) begin
      oc_active_r <= 1'b1;
    end else if (half_end && !matched_r) begin
      oc_active_r <= limit_seen_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // rectifier outputs: off while own primary conducts and for dead time around it
  always_ff @(posedge ref_clk) begin
    if (!resetn || !run_ok) begin
      rect_a_r <= 1'b0;
      rect_b_r <= 1'b0;
    end else begin
      // held off through the start edge too, else rectifier and primary of one side meet for a cycle
      rect_a_r <= !(!side_r && (pri_a_r || phase_r <= DEAD_P || since_off_r < DEAD_P));
      rect_b_r <= !(side_r && (pri_b_r || phase_r <= DEAD_P || since_off_r < DEAD_P));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timer node drive and ramp input selection
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      charge_r <= 1'b0;
      decay_r <= 1'b0;
      tdis_r <= 1'b0;
      ramp_sel_r <= 1'b0;
    end else begin
      charge_r <= charge_nxt;
      decay_r <= !charge_nxt && !low;
      tdis_r <= low;
      ramp_sel_r <= peak_s;
    end
  end

  assign primary_out_a = pri_a_r;
  assign primary_out_b = pri_b_r;
  assign rect_out_a = rect_a_r;
  assign rect_out_b = rect_b_r;
  assign ramp_discharge = discharge_r;
  assign sense_clamp = clamp_r;
  assign ramp_sel_current = ramp_sel_r;
  assign soft_start_pull_low = ss_pull_r;
  assign timer_charge = charge_r;
  assign timer_decay = decay_r;
  assign timer_discharge = tdis_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_side_swap;
    @(posedge ref_clk) disable iff (!resetn)
      (mode_r == ST_RUN && $past(mode_r) == ST_RUN && $changed(side_r)) |-> phase_r == '0;
  endproperty
  a_side_swap: assert property (p_side_swap) else $error("side changed mid ramp period");

  property p_clamp_at_start;
    @(posedge ref_clk) disable iff (!resetn)
      (run_ok && phase_r == ONE && $past(run_ok)) |-> (sense_clamp && ramp_discharge);
  endproperty
  a_clamp_at_start: assert property (p_clamp_at_start) else $error("clamp missing at cycle start");

  property p_clamp_after_rise;
    @(posedge ref_clk) disable iff (!resetn)
      ($rose(pri_on) && run_ok) |-> ((clamp_r || !run_ok) [*7]) ##1 (!clamp_r || !run_ok);
  endproperty
  a_clamp_after_rise: assert property (p_clamp_after_rise) else $error("clamp window wrong");

  property p_min_pulse;
    @(posedge ref_clk) disable iff (!resetn)
      ($fell(pri_a_r) && mode_r == ST_RUN && !trip) |-> $past(pri_a_r, 10);
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("primary pulse under minimum");

  property p_match_width;
    @(posedge ref_clk) disable iff (!resetn)
      ($fell(pri_on) && matched_r && mode_r == ST_RUN && !trip) |-> on_cnt_r == match_w_r;
  endproperty
  a_match_width: assert property (p_match_width) else $error("matched width differs");

  property p_hiccup_off;
    @(posedge ref_clk) disable iff (!resetn)
      (mode_r == ST_HICCUP) |-> !(pri_on || rect_a_r || rect_b_r) && ss_pull_r;
  endproperty
  a_hiccup_off: assert property (p_hiccup_off) else $error("output active in hiccup");

  property p_trip_shutdown;
    @(posedge ref_clk) disable iff (!resetn)
      trip |=> (mode_r == ST_HICCUP && !pri_on && tif.level == TOP_LVL);
  endproperty
  a_trip_shutdown: assert property (p_trip_shutdown) else $error("trip did not shut down");

  property p_timer_reset;
    @(posedge ref_clk) disable iff (!resetn)
      (mode_r == ST_RESTART) |-> (tif.level == '0 && !ss_pull_r && timer_discharge);
  endproperty
  a_timer_reset: assert property (p_timer_reset) else $error("timer not reset at restart");

  property p_charge_on_limit;
    @(posedge ref_clk) disable iff (!resetn)
      (limit_end && run_ok) |=> timer_charge ##1 (tif.level > $past(tif.level));
  endproperty
  a_charge_on_limit: assert property (p_charge_on_limit) else $error("timer not charging");

endmodule
